// File: hw/pmc_consts.vh
// Constants of the power mode controller: register offsets, fields,
// reset values and timing counts. Definitions only.
`ifndef PMC_CONSTS_VH
`define PMC_CONSTS_VH

// Register byte offsets on the AHB-Lite slave.
`define PMC_OFS_MODE 8'h00
`define PMC_OFS_CTRL 8'h04
`define PMC_OFS_WDT_CONTROL_REG 8'h08
`define PMC_OFS_STAT 8'h0C
`define PMC_OFS_WAKE 8'h10

// Mode register fields.
`define PMC_MODE_DIV_HI 7
`define PMC_MODE_DIV_LO 5
`define PMC_MODE_SLOW_RDY 3
`define PMC_MODE_FAST_RDY 2
`define PMC_MODE_IDLE_SEL 1
`define PMC_MODE_FAST_SEL 0

// Control register field and status fields.
`define PMC_CTRL_KEEP 7
`define PMC_STAT_PDF 0
`define PMC_STAT_TO 1

// Reset values.
`define PMC_MODE_RST 8'hC2
`define PMC_CTRL_RST 8'h00
`define PMC_WDT_CONTROL_REG_RST 8'h53
`define PMC_WAKE_RST 8'h00

// Oscillator start-up counts, in cycles of the oscillator concerned.
`define PMC_FAST_SST 16'h0400
`define PMC_SLOW_SST 16'h0400

// Operating states.
`define PMC_ST_RUN 2'h0
`define PMC_ST_SLEEP 2'h1
`define PMC_ST_IDLE_CLOCK_OFF_STATE 2'h2
`define PMC_ST_IDLE_CLOCK_ON_STATE 2'h3

`endif

// File: hw/pmc_power_mode.v
// Power mode controller: clock source selection, halt into sleep or idle,
// wake-up handling, power-down and watchdog flags, and the watchdog.
// Assumes a 25 MHz clk, an AHB-Lite master, and a CPU that pulses halt and
// clear-watchdog; slow_tick is a one-cycle pulse per slow RC period.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.vh"

module pmc_power_mode #(
    parameter NUM_INT = 4,
    parameter FAST_SST = `PMC_FAST_SST,
    parameter SLOW_SST = `PMC_SLOW_SST
) (
    // Clock and reset.
    input wire clk,
    input wire rst_b,
    // AHB-Lite slave.
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // CPU events and status.
    input wire halt_req,
    input wire clr_wdt,
    input wire [NUM_INT-1:0] int_flag,
    input wire [NUM_INT-1:0] int_enable,
    input wire stack_full,
    // Slow RC tick and Port A pins.
    input wire slow_tick,
    input wire [7:0] porta_in,
    // Clock controls.
    output reg fast_osc_en,
    output reg fast_tap_en,
    output reg sys_clk_slow,
    output reg [2:0] sys_div_log2,
    output reg sys_clk_run,
    output reg tbc_run,
    output reg slow_clk_run,
    // Execution control.
    output reg cpu_halted,
    output reg state_hold,
    output reg resume_pulse,
    output reg int_service,
    output reg pc_sp_reset,
    output reg wdt_dev_reset
);

    // Watchdog period as a bit index of the counter.
    function [4:0] wdt_bit;
        input [2:0] sel;
        begin
            case (sel)
                3'h0: wdt_bit = 5'h08;
                3'h1: wdt_bit = 5'h0A;
                3'h2: wdt_bit = 5'h0C;
                3'h3: wdt_bit = 5'h0E;
                3'h4: wdt_bit = 5'h0F;
                3'h5: wdt_bit = 5'h10;
                3'h6: wdt_bit = 5'h11;
                default: wdt_bit = 5'h12;
            endcase
        end
    endfunction

    // Divide ratio as a power of two; zero means the undivided fast clock.
    // Field 111 is fast/2 and 010 fast/64: eight minus the field, mod 8.
    function [2:0] div_log2;
        input fast_sel;
        input [2:0] cks;
        begin
            if (fast_sel) begin
                div_log2 = 3'h0;
            end else begin
                div_log2 = 3'h0 - cks;
            end
        end
    endfunction

    reg [7:0] mode_reg;
    reg [7:0] ctrl_reg;
    reg [7:0] wdt_control_reg_reg;
    reg [7:0] wake_mask;
    reg powerdown_flag;
    reg dog_expiry_flag;
    reg [1:0] state;
    reg [15:0] fast_cnt;
    reg [15:0] slow_cnt;
    reg fast_osc_ready;
    reg slow_osc_ready;
    reg [18:0] wdt_cnt;
    reg [7:0] porta_prev;
    reg [NUM_INT-1:0] int_block;
    reg rd_pend;
    reg wr_pend;
    reg [7:0] addr_q;
    reg slow_active;

    wire [2:0] cks = mode_reg[`PMC_MODE_DIV_HI:`PMC_MODE_DIV_LO];
    wire fast_sel = mode_reg[`PMC_MODE_FAST_SEL];
    // Slow running requested by the select bits.
    wire want_slow = !fast_sel && (cks[2:1] == 2'h0);
    wire low_power = (state != `PMC_ST_RUN);
    wire accept = hsel && hready && htrans[1];
    wire porta_fall = |(porta_prev & ~porta_in & wake_mask);
    wire [NUM_INT-1:0] int_wake = int_flag & ~int_block;
    wire int_ok = |(int_wake & int_enable) && !stack_full;
    wire wdt_over = slow_tick && wdt_cnt[wdt_bit(wdt_control_reg_reg[2:0])];
    wire fast_needed = !slow_active &&
        (state == `PMC_ST_RUN || state == `PMC_ST_IDLE_CLOCK_ON_STATE);
    wire halt_ok = halt_req && (state == `PMC_ST_RUN);

    // Bus handshake; reads take one wait state so earlier writes land first.
    always @(posedge clk) begin
        if (!rst_b) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            rd_pend <= 1'b0;
            wr_pend <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            hresp <= 1'b0;
            rd_pend <= accept && !hwrite;
            wr_pend <= accept && hwrite;
            if (accept) begin
                addr_q <= haddr;
            end
            hreadyout <= !(accept && !hwrite);
        end
    end

    // Read data, loaded during the wait state; unmapped reads give zero.
    always @(posedge clk) begin
        if (!rst_b) begin
            hrdata <= 32'h00000000;
        end else if (rd_pend) begin
            if (addr_q == `PMC_OFS_MODE) begin
                hrdata <= {24'h000000, cks, 1'b0, slow_osc_ready,
                    fast_osc_ready, mode_reg[1:0]};
            end else if (addr_q == `PMC_OFS_CTRL) begin
                hrdata <= {24'h000000, ctrl_reg[7], 7'h00};
            end else if (addr_q == `PMC_OFS_WDT_CONTROL_REG) begin
                hrdata <= {24'h000000, wdt_control_reg_reg};
            end else if (addr_q == `PMC_OFS_STAT) begin
                hrdata <= {30'h00000000, dog_expiry_flag, powerdown_flag};
            end else if (addr_q == `PMC_OFS_WAKE) begin
                hrdata <= {24'h000000, wake_mask};
            end else begin
                hrdata <= 32'h00000000;
            end
        end
    end

    // Software registers; a halt leaves them all untouched.
    always @(posedge clk) begin
        if (!rst_b) begin
            mode_reg <= `PMC_MODE_RST;
            ctrl_reg <= `PMC_CTRL_RST;
            wdt_control_reg_reg <= `PMC_WDT_CONTROL_REG_RST;
            wake_mask <= `PMC_WAKE_RST;
        end else if (wr_pend) begin
            // Clock bits change only by software writes here.
            if (addr_q == `PMC_OFS_MODE) begin
                mode_reg <= {hwdata[7:5], 3'h0, hwdata[1:0]};
            end else if (addr_q == `PMC_OFS_CTRL) begin
                ctrl_reg <= {hwdata[7], 7'h00};
            end else if (addr_q == `PMC_OFS_WDT_CONTROL_REG) begin
                wdt_control_reg_reg <= hwdata[7:0];
            end else if (addr_q == `PMC_OFS_WAKE) begin
                wake_mask <= hwdata[7:0];
            end
        end
    end

    // Operating state and wake-up decisions.
    always @(posedge clk) begin
        if (!rst_b) begin
            state <= `PMC_ST_RUN;
            int_block <= {NUM_INT{1'b0}};
            resume_pulse <= 1'b0;
            int_service <= 1'b0;
            pc_sp_reset <= 1'b0;
            wdt_dev_reset <= 1'b0;
        end else begin
            resume_pulse <= 1'b0;
            int_service <= 1'b0;
            pc_sp_reset <= 1'b0;
            wdt_dev_reset <= 1'b0;
            case (state)
                `PMC_ST_RUN: begin
                    if (halt_ok) begin
                        int_block <= int_flag;
                        if (!mode_reg[`PMC_MODE_IDLE_SEL]) begin
                            state <= `PMC_ST_SLEEP;
                        end else if (!ctrl_reg[`PMC_CTRL_KEEP]) begin
                            state <= `PMC_ST_IDLE_CLOCK_OFF_STATE;
                        end else begin
                            state <= `PMC_ST_IDLE_CLOCK_ON_STATE;
                        end
                    end else if (wdt_over) begin
                        wdt_dev_reset <= 1'b1;
                    end
                end
                default: begin
                    // Watchdog wake wins over the other sources.
                    if (wdt_over) begin
                        state <= `PMC_ST_RUN;
                        pc_sp_reset <= 1'b1;
                    end else if (porta_fall) begin
                        state <= `PMC_ST_RUN;
                        resume_pulse <= 1'b1;
                    end else if (|int_wake) begin
                        state <= `PMC_ST_RUN;
                        int_service <= int_ok;
                        resume_pulse <= !int_ok;
                    end
                end
            endcase
        end
    end

    // Power-down and expiry flags; an event beats a clear in the same cycle.
    always @(posedge clk) begin
        if (!rst_b) begin
            powerdown_flag <= 1'b0;
            dog_expiry_flag <= 1'b0;
        end else begin
            if (halt_ok) begin
                powerdown_flag <= 1'b1;
            end else if (clr_wdt) begin
                powerdown_flag <= 1'b0;
            end
            if (wdt_over) begin
                dog_expiry_flag <= 1'b1;
            end else if (halt_ok) begin
                dog_expiry_flag <= 1'b0;
            end
        end
    end

    // Watchdog counter on slow ticks; the halt clears it and it resumes.
    always @(posedge clk) begin
        if (!rst_b) begin
            wdt_cnt <= 19'h00000;
        end else if (halt_ok || clr_wdt || wdt_over) begin
            wdt_cnt <= 19'h00000;
        end else if (slow_tick) begin
            wdt_cnt <= wdt_cnt + 19'h00001;
        end
    end

    // Port A sampling; inputs arrive synchronous, one register finds edges.
    always @(posedge clk) begin
        if (!rst_b) begin
            porta_prev <= 8'hFF;
        end else begin
            porta_prev <= porta_in;
        end
    end

    // Slow oscillator ready after its start-up count of slow ticks.
    always @(posedge clk) begin
        if (!rst_b) begin
            slow_cnt <= 16'h0000;
            slow_osc_ready <= 1'b0;
        end else if (slow_tick && !slow_osc_ready) begin
            slow_cnt <= slow_cnt + 16'h0001;
            slow_osc_ready <= (slow_cnt == SLOW_SST[15:0] - 16'h0001);
        end
    end

    // Fast oscillator ready: low while stopped, counts up once restarted.
    always @(posedge clk) begin
        if (!rst_b) begin
            fast_cnt <= 16'h0000;
            fast_osc_ready <= 1'b0;
        end else if (!fast_needed) begin
            fast_cnt <= 16'h0000;
            fast_osc_ready <= 1'b0;
        end else if (!fast_osc_ready) begin
            fast_cnt <= fast_cnt + 16'h0001;
            fast_osc_ready <= (fast_cnt == FAST_SST[15:0] - 16'h0001);
        end
    end

    // Slow source takes over only once the slow oscillator is stable.
    always @(posedge clk) begin
        if (!rst_b) begin
            slow_active <= 1'b0;
        end else if (!want_slow) begin
            slow_active <= 1'b0;
        end else if (slow_osc_ready) begin
            slow_active <= 1'b1;
        end
    end

    // Clock control outputs follow the state and the held select bits.
    always @(posedge clk) begin
        if (!rst_b) begin
            fast_osc_en <= 1'b1;
            fast_tap_en <= 1'b1;
            sys_clk_slow <= 1'b0;
            sys_div_log2 <= 3'h0;
            sys_clk_run <= 1'b1;
            tbc_run <= 1'b1;
            slow_clk_run <= 1'b1;
            cpu_halted <= 1'b0;
            state_hold <= 1'b0;
        end else begin
            fast_osc_en <= fast_needed;
            fast_tap_en <= fast_needed;
            sys_clk_slow <= slow_active;
            sys_div_log2 <= div_log2(fast_sel, cks);
            sys_clk_run <= (state == `PMC_ST_RUN) ||
                (state == `PMC_ST_IDLE_CLOCK_ON_STATE);
            tbc_run <= (state != `PMC_ST_SLEEP);
            slow_clk_run <= 1'b1;
            cpu_halted <= low_power;
            state_hold <= low_power;
        end
    end

endmodule

`default_nettype wire

// File: tb/pmc_power_mode_monitor.sv
// Port checker of the power mode controller.
// Assumes one clock, synchronous active-low reset, hready tied to hreadyout.
`timescale 1ns/1ps
`default_nettype none
module pmc_power_mode_monitor #(
    parameter NUM_INT = 4
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Bus.
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // Events and controls.
    input wire logic halt_req,
    input wire logic fast_osc_en,
    input wire logic fast_tap_en,
    input wire logic sys_clk_slow,
    input wire logic sys_clk_run,
    input wire logic tbc_run,
    input wire logic slow_clk_run,
    input wire logic cpu_halted,
    input wire logic resume_pulse,
    input wire logic int_service,
    input wire logic pc_sp_reset,
    input wire logic wdt_dev_reset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Any wake pulse; several sources share the exit timing.
    wire wake_any = resume_pulse | int_service | pc_sp_reset;
    // Exit from low power lands one cycle after the wake pulse.
    sequence s_leave;
        cpu_halted ##1 !cpu_halted;
    endsequence
    sequence s_read_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    property p_halt_enter;
        halt_req && !cpu_halted && !wake_any |-> ##2 cpu_halted;
    endproperty
    property p_halt_cause;
        $rose(cpu_halted) |-> $past(halt_req, 2);
    endproperty
    property p_pulse_single;
        wake_any |=> !wake_any;
    endproperty
    property p_wake_exit;
        wake_any |-> s_leave;
    endproperty
    property p_wdt_only;
        pc_sp_reset |-> !resume_pulse && !int_service && !wdt_dev_reset;
    endproperty
    property p_taps;
        fast_tap_en == fast_osc_en;
    endproperty
    property p_fast_stop;
        $rose(sys_clk_slow) |-> ##[0:2] !fast_osc_en;
    endproperty
    property p_sleep_clocks;
        cpu_halted && !tbc_run |-> !sys_clk_run && !fast_osc_en;
    endproperty
    property p_idle_clock_on_state_clocks;
        cpu_halted && sys_clk_run |-> tbc_run && slow_clk_run;
    endproperty
    property p_read_wait;
        hsel && hready && htrans[1] && !hwrite |=> s_read_wait;
    endproperty
    property p_okay;
        !hresp;
    endproperty
    a_halt_enter: assert property (p_halt_enter)
        else $error("halt not followed by low power");
    a_halt_cause: assert property (p_halt_cause)
        else $error("low power entered without halt");
    a_pulse_single: assert property (p_pulse_single)
        else $error("wake pulse longer than one cycle");
    a_wake_exit: assert property (p_wake_exit)
        else $error("wake pulse without exit from low power");
    a_wdt_only: assert property (p_wdt_only)
        else $error("watchdog wake mixed with other response");
    a_taps: assert property (p_taps)
        else $error("fast taps differ from fast oscillator");
    a_fast_stop: assert property (p_fast_stop)
        else $error("fast oscillator kept on in slow running");
    a_sleep_clocks: assert property (p_sleep_clocks)
        else $error("system clock running in sleep");
    a_idle_clock_on_state_clocks: assert property (p_idle_clock_on_state_clocks)
        else $error("idle clocks inconsistent");
    a_read_wait: assert property (p_read_wait)
        else $error("read wait state wrong");
    a_okay: assert property (p_okay)
        else $error("error response seen");
endmodule
bind pmc_power_mode pmc_power_mode_monitor #(.NUM_INT(NUM_INT))
    u_pmc_power_mode_monitor (.clk(clk), .rst_b(rst_b), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .halt_req(halt_req),
    .fast_osc_en(fast_osc_en), .fast_tap_en(fast_tap_en),
    .sys_clk_slow(sys_clk_slow), .sys_clk_run(sys_clk_run),
    .tbc_run(tbc_run), .slow_clk_run(slow_clk_run),
    .cpu_halted(cpu_halted), .resume_pulse(resume_pulse),
    .int_service(int_service), .pc_sp_reset(pc_sp_reset),
    .wdt_dev_reset(wdt_dev_reset));
`default_nettype wire

// File: tb/power_mode_controller_test.sv
// Self-checking bench of the power mode controller.
// Assumes short start-up counts of 4 and a slow tick every 4 clocks.
`timescale 1ns/1ps
`default_nettype none
module power_mode_controller_test;
    // Stimulus.
    logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic halt_req = 1'b0, clr_wdt = 1'b0, slow_tick = 1'b0, stack_full = 1'b0;
    logic [7:0] haddr = 8'h00, porta_in = 8'hFF;
    logic [1:0] htrans = 2'h0, tick_cnt = 2'h0;
    logic [31:0] hwdata = 32'h0, rd;
    logic [3:0] int_flag = 4'h0, int_enable = 4'h1;
    // Observed outputs.
    wire [31:0] hrdata;
    wire [2:0] sys_div_log2;
    wire hreadyout, hresp, fast_osc_en, fast_tap_en, sys_clk_slow;
    wire sys_clk_run, tbc_run, slow_clk_run, cpu_halted, state_hold;
    wire resume_pulse, int_service, pc_sp_reset, wdt_dev_reset;
    wire [2:0] ev = {pc_sp_reset, int_service, resume_pulse};
    int errors = 0, n_tests = 0, i, n;
    pmc_power_mode #(.FAST_SST(4), .SLOW_SST(4)) u_pmc_power_mode (
        .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .halt_req(halt_req), .clr_wdt(clr_wdt),
        .int_flag(int_flag), .int_enable(int_enable),
        .stack_full(stack_full), .slow_tick(slow_tick), .porta_in(porta_in),
        .fast_osc_en(fast_osc_en), .fast_tap_en(fast_tap_en),
        .sys_clk_slow(sys_clk_slow), .sys_div_log2(sys_div_log2),
        .sys_clk_run(sys_clk_run), .tbc_run(tbc_run),
        .slow_clk_run(slow_clk_run), .cpu_halted(cpu_halted),
        .state_hold(state_hold), .resume_pulse(resume_pulse),
        .int_service(int_service), .pc_sp_reset(pc_sp_reset),
        .wdt_dev_reset(wdt_dev_reset));
    always #20 clk = ~clk;
    // Slow RC stand-in: a short period keeps watchdog runs brief.
    always @(posedge clk) begin
        tick_cnt <= tick_cnt + 2'h1;
        slow_tick <= (tick_cnt == 2'h3);
    end
    task chk(input [31:0] got, input [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One single AHB-Lite word transfer; waits only on hreadyout.
    task xfer(input w, input [7:0] a, input [7:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= {24'h0, d};
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task rdchk(input [7:0] a, input [7:0] exp);
        xfer(1'b0, a, 8'h00);
        chk(rd, {24'h0, exp});
    endtask
    // Halt pulse, then let state and clock outputs settle.
    task halt;
        @(posedge clk);
        halt_req <= 1'b1;
        @(posedge clk);
        halt_req <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task wait_ev(input [2:0] m);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while ((ev & m) == 3'h0 && n < 3000);
        chk({29'h0, ev}, {29'h0, m});
    endtask
    task close_out;
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Watchdog against a hang; the tests need under 1500 of the 20000 cycles allowed.
    initial begin
        #(40 * 20000);
        errors++;
        close_out;
    end
    // Main sequence.
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (40) @(posedge clk);
        rdchk(8'h00, 8'hCE);
        rdchk(8'h04, 8'h00);
        rdchk(8'h08, 8'h53);
        rdchk(8'h0C, 8'h00);
        xfer(1'b1, 8'h14, 8'hFF);
        rdchk(8'h14, 8'h00);
        xfer(1'b1, 8'h00, 8'hF3);
        rdchk(8'h00, 8'hEF);
        chk({28'h0, sys_clk_slow, sys_div_log2}, 32'h0);
        for (i = 0; i < 8; i++) begin
            xfer(1'b1, 8'h00, {i[2:0], 5'h00});
            repeat (16) @(posedge clk);
            #1;
            chk({31'h0, sys_clk_slow}, {31'h0, i < 2});
            chk({31'h0, fast_osc_en}, {31'h0, i >= 2});
            if (i >= 2) chk({29'h0, sys_div_log2}, 8 - i);
        end
        // Back on the fast clock: software checks the ready flag first.
        rdchk(8'h00, 8'hEC);
        xfer(1'b1, 8'h00, 8'hC0);
        xfer(1'b1, 8'h10, 8'h01);
        halt;
        chk({27'h0, cpu_halted, state_hold, sys_clk_run, tbc_run,
            fast_osc_en}, 32'h18);
        rdchk(8'h00, 8'hC8);
        @(posedge clk);
        porta_in <= 8'hFD;
        repeat (8) @(posedge clk);
        #1;
        chk({31'h0, cpu_halted}, 32'h1);
        @(posedge clk);
        porta_in <= 8'hFC;
        wait_ev(3'h1);
        @(posedge clk);
        #1;
        chk({27'h0, cpu_halted, sys_clk_run, sys_div_log2}, 32'h0A);
        porta_in <= 8'hFF;
        rdchk(8'h0C, 8'h01);
        clr_wdt <= 1'b1;
        @(posedge clk);
        clr_wdt <= 1'b0;
        rdchk(8'h0C, 8'h00);
        xfer(1'b1, 8'h00, 8'hC2);
        halt;
        chk({29'h0, cpu_halted, sys_clk_run, tbc_run}, 32'h5);
        @(posedge clk);
        int_flag <= 4'h1;
        wait_ev(3'h2);
        int_flag <= 4'h0;
        xfer(1'b1, 8'h04, 8'h80);
        int_flag <= 4'h1;
        halt;
        chk({29'h0, cpu_halted, sys_clk_run, tbc_run}, 32'h7);
        repeat (8) @(posedge clk);
        #1;
        chk({31'h0, cpu_halted}, 32'h1);
        @(posedge clk);
        int_flag <= 4'h3;
        wait_ev(3'h1);
        int_flag <= 4'h0;
        // Enabled interrupt but a full stack only resumes after the halt.
        stack_full <= 1'b1;
        halt;
        @(posedge clk);
        int_flag <= 4'h1;
        wait_ev(3'h1);
        int_flag <= 4'h0;
        stack_full <= 1'b0;
        xfer(1'b1, 8'h04, 8'h00);
        xfer(1'b1, 8'h08, 8'h50);
        xfer(1'b1, 8'h00, 8'hC0);
        halt;
        wait_ev(3'h4);
        chk({31'h0, n > 1010 && n < 1030}, 32'h1);
        rdchk(8'h0C, 8'h03);
        rdchk(8'h08, 8'h50);
        close_out;
    end
endmodule
`default_nettype wire
